// File: core/machine_check_status.sv
// machine check cause status register with write-one-to-clear access and interrupt request
//
// Functional notes
// RQ1 - asynchronous machine check sets summary plus cause
// RQ2 - interrupt when check enable and summary set
// RQ3 - write is clear mask: one clears bit
// RQ4 - summary set always with exactly one cause
// RQ5 - bit 1: instruction read bus error
// RQ6 - bit 2: data read bus error
// RQ7 - bit 3: data write bus error
// RQ8 - bit 4: translation buffer parity error
// RQ9 - bit 5: instruction cache parity error
// RQ10 - bit 6: data cache search parity only
// RQ11 - bit 7: data cache flush parity only
// RQ12 - bit 8: event while check enable is 0
// RQ13 - bits sticky until cleared; reserved read zero
module machine_check_status #(
    parameter int REG_WIDTH = 32
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // exception reports and machine state
    input  wire mcheck_pkg::check_event_s checkEvent,
    input  wire logic                    checkEnable,
    // special register access
    input  wire mcheck_pkg::spr_req_s    sprReq,
    output logic [REG_WIDTH-1:0]         sprRdData,
    // status view and interrupt request
    output logic [REG_WIDTH-1:0]         machine_check_cause_status,
    output logic                         machineCheckIrq
);
    import mcheck_pkg::*;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (REG_WIDTH != STATUS_WIDTH) begin : g_width_check
        $error("machine_check_status: REG_WIDTH must equal the 32-bit register width");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [USED_BITS-1:0] status;
        logic [REG_WIDTH-1:0] rdData;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic [USED_BITS-1:0] setBits;
    logic [USED_BITS-1:0] clrBits;
    logic                 takeEvent;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        setBits   = '0;
        clrBits   = '0;
        takeEvent = checkEvent.valid && checkEvent.async;
        if (takeEvent) begin
            // summary and cause always land in the same update
            unique case (checkEvent.cause)
                CAUSE_INSTR_READ_BUS: begin
                    setBits[POS_INSTR_READ_BUS] = 1'b1; // RQ5
                end
                CAUSE_DATA_READ_BUS: begin
                    setBits[POS_DATA_READ_BUS] = 1'b1; // RQ6
                end
                CAUSE_DATA_WRITE_BUS: begin
                    setBits[POS_DATA_WRITE_BUS] = 1'b1; // RQ7
                end
                CAUSE_TRANSLATION_PAR: begin
                    setBits[POS_TRANSLATION_PAR] = 1'b1; // RQ8
                end
                CAUSE_ICACHE_PAR: begin
                    setBits[POS_ICACHE_PAR] = 1'b1; // RQ9
                end
                CAUSE_DCACHE_SEARCH_PAR: begin
                    setBits[POS_DCACHE_SEARCH] = 1'b1; // RQ10
                end
                CAUSE_DCACHE_FLUSH_PAR: begin
                    setBits[POS_DCACHE_FLUSH] = 1'b1; // RQ11
                end
                default: begin
                    // an event without a cause is dropped so no event sets the summary alone
                    setBits = '0;
                end
            endcase
            if (setBits != '0) begin
                setBits[POS_SUMMARY] = 1'b1; // RQ1 RQ4
                // flagged whether or not the summary was already pending
                setBits[POS_IMPRECISE] = !checkEnable; // RQ12
            end
        end
        if (sprReq.wrEn) begin
            clrBits = sprReq.wrMask[USED_BITS-1:0] & USED_MASK; // RQ3
        end
        state_d        = state_q;
        // a set in the cycle of its clear wins, so no event is lost
        state_d.status = (state_q.status & ~clrBits) | setBits; // RQ3 RQ13
        if (sprReq.rdEn) begin
            // reads return the value before this cycle's update; reserved bits read zero
            state_d.rdData = {{(REG_WIDTH-USED_BITS){1'b0}}, state_q.status}; // RQ13
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q.status <= STATUS_RESET[USED_BITS-1:0];
            state_q.rdData <= STATUS_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign sprRdData                  = state_q.rdData;
    assign machine_check_cause_status = {{(REG_WIDTH-USED_BITS){1'b0}}, state_q.status};
    assign machineCheckIrq            = checkEnable && state_q.status[POS_SUMMARY]; // RQ2

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic validCause;
    assign validCause = checkEvent.cause != CAUSE_NONE;

    a_summary_on_event: assert property ( // RQ1
        checkEvent.valid && checkEvent.async && validCause
        |=> machine_check_cause_status[POS_SUMMARY]
            && machine_check_cause_status[$past(checkEvent.cause)]
    ) else $error("summary or cause missing after asynchronous event");

    a_irq_follows_state: assert property ( // RQ2
        machineCheckIrq == (checkEnable && machine_check_cause_status[POS_SUMMARY])
    ) else $error("interrupt request disagrees with enable and summary");

    a_clear_mask_works: assert property ( // RQ3
        sprReq.wrEn && !(checkEvent.valid && checkEvent.async && validCause)
        |=> (machine_check_cause_status & $past(sprReq.wrMask)) == '0
    ) else $error("write mask failed to clear status bits");

    a_zero_mask_keeps: assert property ( // RQ3
        sprReq.wrEn && sprReq.wrMask == '0 |=> $stable(machine_check_cause_status)
            || $past(checkEvent.valid && checkEvent.async)
    ) else $error("zero write mask changed status");

    a_one_cause_set: assert property ( // RQ4
        $rose(machine_check_cause_status[POS_SUMMARY])
        |-> $onehot0(machine_check_cause_status[CAUSE_LAST:CAUSE_FIRST]
                     & ~$past(machine_check_cause_status[CAUSE_LAST:CAUSE_FIRST]))
            && $past(checkEvent.cause) != CAUSE_NONE
            && machine_check_cause_status[$past(checkEvent.cause)]
    ) else $error("summary rose without exactly one new cause");

    a_search_only: assert property ( // RQ10
        $rose(machine_check_cause_status[POS_DCACHE_SEARCH])
        |-> $past(checkEvent.valid && checkEvent.cause == CAUSE_DCACHE_SEARCH_PAR)
    ) else $error("search parity bit set without search parity event");

    a_flush_only: assert property ( // RQ11
        $rose(machine_check_cause_status[POS_DCACHE_FLUSH])
        |-> $past(checkEvent.valid && checkEvent.cause == CAUSE_DCACHE_FLUSH_PAR)
    ) else $error("flush parity bit set without flush parity event");

    a_imprecise_flag: assert property ( // RQ12
        checkEvent.valid && checkEvent.async && validCause
        |=> machine_check_cause_status[POS_IMPRECISE] == ($past(!checkEnable)
            || $past(machine_check_cause_status[POS_IMPRECISE] && !sprReq.wrMask[POS_IMPRECISE])
            || $past(machine_check_cause_status[POS_IMPRECISE] && !sprReq.wrEn))
    ) else $error("imprecise flag wrong after event");

    a_sticky_bits: assert property ( // RQ13
        !sprReq.wrEn |=> ($past(machine_check_cause_status) & ~machine_check_cause_status) == '0
    ) else $error("status bit dropped without a clear");

    a_reserved_zero: assert property ( // RQ13
        machine_check_cause_status[31:USED_BITS] == '0 && sprRdData[31:USED_BITS] == '0
    ) else $error("reserved bits not zero");

    a_read_value: assert property ( // RQ13
        sprReq.rdEn |=> sprRdData == $past(machine_check_cause_status)
    ) else $error("read data does not match status");

    a_read_holds: assert property ( // RQ13
        !sprReq.rdEn |=> $stable(sprRdData)
    ) else $error("read data changed without a read");

    a_no_event_stable: assert property ( // RQ1 RQ13
        !(checkEvent.valid && checkEvent.async && validCause) && !sprReq.wrEn
        |=> $stable(machine_check_cause_status)
    ) else $error("status changed with no event and no clear");

    a_enabled_no_flag: assert property ( // RQ12
        checkEvent.valid && checkEvent.async && validCause && checkEnable
        && !machine_check_cause_status[POS_IMPRECISE]
        |=> !machine_check_cause_status[POS_IMPRECISE]
    ) else $error("imprecise flag set while checks were enabled");

    a_set_beats_clear: assert property ( // RQ1
        checkEvent.valid && checkEvent.async && validCause && sprReq.wrEn
        |=> machine_check_cause_status[POS_SUMMARY]
    ) else $error("clear in the event cycle lost the summary");

    c_event_enabled: cover property (
        checkEvent.valid && checkEvent.async && checkEnable ##1 machineCheckIrq
    );
    c_event_disabled: cover property (
        checkEvent.valid && checkEvent.async && !checkEnable && validCause
    );
    c_set_and_clear: cover property (
        checkEvent.valid && checkEvent.async && validCause && sprReq.wrEn && sprReq.wrMask[0]
    );
    c_clear_all: cover property (
        machine_check_cause_status[POS_SUMMARY] ##1 sprReq.wrEn ##1
        machine_check_cause_status == '0
    );
    c_flag_on_pending: cover property (
        machine_check_cause_status[POS_SUMMARY] && !checkEnable
        && checkEvent.valid && checkEvent.async && validCause
    );

endmodule

// File: shared/mcheck_pkg.sv
// package: field layout, reset value and carrier types of the machine check status logic
package mcheck_pkg;

    // ************************************************************
    // register layout
    // ************************************************************
    localparam int          STATUS_WIDTH        = 32;
    localparam int          USED_BITS           = 9;
    localparam int          POS_SUMMARY         = 0;
    localparam int          POS_INSTR_READ_BUS  = 1;
    localparam int          POS_DATA_READ_BUS   = 2;
    localparam int          POS_DATA_WRITE_BUS  = 3;
    localparam int          POS_TRANSLATION_PAR = 4;
    localparam int          POS_ICACHE_PAR      = 5;
    localparam int          POS_DCACHE_SEARCH   = 6;
    localparam int          POS_DCACHE_FLUSH    = 7;
    localparam int          POS_IMPRECISE       = 8;
    localparam int          CAUSE_FIRST         = 1;
    localparam int          CAUSE_LAST          = 7;
    localparam logic [31:0] STATUS_RESET        = 32'h0000_0000;
    localparam logic [8:0]  USED_MASK           = 9'h1FF;

    // ************************************************************
    // event cause codes: each code other than CAUSE_NONE equals the bit position it sets
    // ************************************************************
    typedef enum logic [2:0] {
        CAUSE_NONE              = 3'h0,
        CAUSE_INSTR_READ_BUS    = 3'h1,
        CAUSE_DATA_READ_BUS     = 3'h2,
        CAUSE_DATA_WRITE_BUS    = 3'h3,
        CAUSE_TRANSLATION_PAR   = 3'h4,
        CAUSE_ICACHE_PAR        = 3'h5,
        CAUSE_DCACHE_SEARCH_PAR = 3'h6,
        CAUSE_DCACHE_FLUSH_PAR  = 3'h7
    } cause_e;

    // one machine check exception report from the core
    typedef struct packed {
        logic   valid;
        logic   async;
        cause_e cause;
    } check_event_s;

    // special register access from the move-to / move-from path
    typedef struct packed {
        logic        rdEn;
        logic        wrEn;
        logic [31:0] wrMask;
    } spr_req_s;

endpackage

// File: bench/tb.sv
// self-checking testbench for the machine check cause status logic
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcheck_pkg::*;

    logic         clk;
    logic         rst_b;
    check_event_s checkEvent;
    logic         checkEnable;
    spr_req_s     sprReq;
    logic [31:0]  sprRdData;
    logic [31:0]  status;
    logic         machineCheckIrq;
    int           error_cnt;
    int           comparisons;

    machine_check_status #(.REG_WIDTH(32)) u_machine_check_status (
        .clk                        (clk),
        .rst_b                      (rst_b),
        .checkEvent                 (checkEvent),
        .checkEnable                (checkEnable),
        .sprReq                     (sprReq),
        .sprRdData                  (sprRdData),
        .machine_check_cause_status (status),
        .machineCheckIrq            (machineCheckIrq)
    );

    always #20 clk = ~clk;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic irq_is(input logic exp);
        check({31'h0, machineCheckIrq}, {31'h0, exp});
    endtask

    // every driver ends with an idle edge, so the next call never lands in the same step
    task automatic ev(input cause_e c);
        checkEvent = '{valid: 1'b1, async: 1'b1, cause: c};
        tick;
        checkEvent = '0;
        tick;
    endtask

    task automatic spr(input logic rd, input logic wr, input logic [31:0] mask);
        sprReq = '{rdEn: rd, wrEn: wr, wrMask: mask};
        tick;
        sprReq = '0;
        tick;
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset;
        check(status, 32'h0000_0000);
        check(sprRdData, 32'h0000_0000);
        irq_is(1'b0);
        $display("test_reset finished");
    endtask

    task automatic test_causes;
        logic [31:0] exp;
        checkEnable = 1'b1;
        for (int c = 1; c <= 7; c++) begin
            exp = 32'h0000_0001 | (32'h0000_0001 << c);
            ev(cause_e'(c));
            check(status, exp);
            irq_is(1'b1);
            spr(1'b1, 1'b0, 32'h0000_0000);
            check(sprRdData, exp);
            spr(1'b0, 1'b1, 32'hFFFF_FFFF);
            check(status, 32'h0000_0000);
            irq_is(1'b0);
        end
        $display("test_causes finished");
    endtask

    task automatic test_imprecise;
        checkEnable = 1'b0;
        ev(CAUSE_TRANSLATION_PAR);
        check(status, 32'h0000_0111);
        irq_is(1'b0);
        checkEnable = 1'b1;
        tick;
        irq_is(1'b1);
        spr(1'b0, 1'b1, 32'h0000_0001);
        check(status, 32'h0000_0110);
        irq_is(1'b0);
        spr(1'b0, 1'b1, 32'hFFFF_FE00);
        check(status, 32'h0000_0110);
        ev(CAUSE_DCACHE_SEARCH_PAR);
        check(status, 32'h0000_0151);
        spr(1'b0, 1'b1, 32'hFFFF_FFFF);
        check(status, 32'h0000_0000);
        $display("test_imprecise finished");
    endtask

    task automatic test_ignored;
        checkEnable = 1'b0;
        checkEvent = '{valid: 1'b1, async: 1'b0, cause: CAUSE_DATA_WRITE_BUS};
        tick;
        checkEvent = '{valid: 1'b1, async: 1'b1, cause: CAUSE_NONE};
        tick;
        checkEvent = '{valid: 1'b0, async: 1'b1, cause: CAUSE_DATA_READ_BUS};
        tick;
        checkEvent = '0;
        tick;
        check(status, 32'h0000_0000);
        $display("test_ignored finished");
    endtask

    task automatic test_set_clear;
        checkEnable = 1'b1;
        checkEvent = '{valid: 1'b1, async: 1'b1, cause: CAUSE_DATA_WRITE_BUS};
        tick;
        checkEvent = '{valid: 1'b1, async: 1'b1, cause: CAUSE_DCACHE_FLUSH_PAR};
        tick;
        checkEvent = '0;
        tick;
        check(status, 32'h0000_0089);
        // event, clear-all and read in one cycle: set wins, read sees the old word
        checkEvent = '{valid: 1'b1, async: 1'b1, cause: CAUSE_INSTR_READ_BUS};
        sprReq = '{rdEn: 1'b1, wrEn: 1'b1, wrMask: 32'hFFFF_FFFF};
        tick;
        checkEvent = '0;
        sprReq = '0;
        tick;
        check(sprRdData, 32'h0000_0089);
        check(status, 32'h0000_0003);
        irq_is(1'b1);
        // summary already pending: the flag still rises while checks are off
        checkEnable = 1'b0;
        ev(CAUSE_DATA_READ_BUS);
        check(status, 32'h0000_0107);
        irq_is(1'b0);
        spr(1'b0, 1'b1, 32'hFFFF_FFFF);
        check(status, 32'h0000_0000);
        check(sprRdData, 32'h0000_0089);
        $display("test_set_clear finished");
    endtask

    task automatic test_mid_reset;
        checkEnable = 1'b1;
        ev(CAUSE_ICACHE_PAR);
        spr(1'b1, 1'b0, 32'h0000_0000);
        check(sprRdData, 32'h0000_0021);
        rst_b = 1'b0;
        tick;
        check(status, 32'h0000_0000);
        check(sprRdData, 32'h0000_0000);
        irq_is(1'b0);
        rst_b = 1'b1;
        ev(CAUSE_DATA_READ_BUS);
        check(status, 32'h0000_0005);
        irq_is(1'b1);
        spr(1'b0, 1'b1, 32'hFFFF_FFFF);
        check(status, 32'h0000_0000);
        $display("test_mid_reset finished");
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        checkEvent = '0;
        checkEnable = 1'b0;
        sprReq = '0;
        error_cnt = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'b1;
        test_reset;
        test_causes;
        test_imprecise;
        test_ignored;
        test_set_clear;
        test_mid_reset;
        final_report;
    end

    // hang guard: far beyond the roughly 80 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report;
    end
endmodule
